// [fbh_pkg.sv]
// package for the parallel flash bus host controller
`default_nettype none
package fbh_pkg;
    // ****************************************************************
    // widths and timing
    // ****************************************************************
    localparam int ADDR_W       = 19;
    localparam int DATA_W       = 16;
    localparam int CLK_MHZ      = 20;
    localparam int T_SETUP_NS   = 100;
    localparam int T_STROBE_NS  = 100;
    localparam int T_RESET_NS   = 500;
    localparam int SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC   = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_CYC    = (T_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 8;
    // sector protect address bit positions
    localparam int PROT_A6      = 6;
    localparam int PROT_A1      = 1;
    localparam int PROT_A0      = 0;

    // ****************************************************************
    // host request operations
    // ****************************************************************
    typedef enum logic [2:0] {
        FBH_OP_READ      = 3'h0,
        FBH_OP_WRITE     = 3'h1,
        FBH_OP_RESET     = 3'h2,
        FBH_OP_PROTECT   = 3'h3,
        FBH_OP_UNPROTECT = 3'h4
    } fbh_op_t;

    typedef struct packed {
        fbh_op_t            op;
        logic               byte_mode;
        logic               low_addr;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
    } fbh_req_t;

    // pins driven toward the flash
    typedef struct packed {
        logic               chip_select_n;
        logic               output_enable_n;
        logic               write_strobe_n;
        logic               hw_reset_n;
        logic               elevated_control_level;
        logic               width_select_n;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  dq_out;
        logic [DATA_W-1:0]  dq_oe;
    } fbh_pins_t;
endpackage : fbh_pkg
`default_nettype wire

// [fbh_host.sv]
// host-side controller driving the flash parallel bus pins
// Operation
// [RULE_01] reads drive select and output enable low, write strobe high, valid address
// [RULE_02] writes drive write strobe and select low with output enable high
// [RULE_03] width select high gives sixteen active data lines
// [RULE_04] width select low: only low eight lines used, lines eight..fourteen floated
// [RULE_05] byte mode: top data pin carries lowest address bit as an input to flash
// [RULE_06] address eighteen..zero word mode, plus extra low bit in byte mode
// [RULE_07] after power-up or hardware reset flash reads array data without command
// [RULE_08] flash stays in array read until a write changes its command register
// [RULE_09] command register is unaddressed latches feeding the flash state machine
// [RULE_10] width select decides byte or word program data
// [RULE_11] fast program mode needs two write cycles per byte or word
// [RULE_12] erase covers sector, several sectors or whole array by sector address
// [RULE_13] id read mode returns codes on low eight lines with read timing
// [RULE_14] protect write: elevated reset level, writes low, A6 low, A1 high, A0 low
// [RULE_15] unprotect write: same levels but A6 high
// [RULE_16] output enable high floats flash data outputs
// [RULE_17] reset low aborts, floats outputs, ignores cycles, returns to array read
// [RULE_18] standby floats outputs regardless of output enable
`default_nettype none
module fbh_host #(
    parameter int ADDR_W = fbh_pkg::ADDR_W,
    parameter int DATA_W = fbh_pkg::DATA_W
) (
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire fbh_pkg::fbh_req_t   req,
    input  wire logic                req_valid,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output logic [DATA_W-1:0]        rsp_data,
    output fbh_pkg::fbh_pins_t       pins,
    input  wire logic [DATA_W-1:0]   dq_in
);
    // ****************************************************************
    // sequencer
    // ****************************************************************
    typedef enum logic [3:0] {
        FBH_IDLE   = 4'h1,
        FBH_SETUP  = 4'h2,
        FBH_STROBE = 4'h4,
        FBH_HOLD   = 4'h8
    } fbh_state_t;
    // one-hot: a stray code lands in the default arm and returns to standby

    fbh_state_t                 state_reg, state_next;
    logic [fbh_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
    fbh_pkg::fbh_req_t          cur_reg, cur_next;
    fbh_pkg::fbh_pins_t         pins_reg, pins_next;
    logic                       ready_reg, ready_next;
    logic                       rv_reg, rv_next;
    logic [DATA_W-1:0]          rd_reg, rd_next;

    // ****************************************************************
    // phase lengths
    // ****************************************************************
    // loaded one short: the cycle on which the count reads zero is still the last of its phase
    localparam logic [fbh_pkg::CNT_W-1:0] SETUP_N  = fbh_pkg::CNT_W'(fbh_pkg::SETUP_CYC - 1);
    localparam logic [fbh_pkg::CNT_W-1:0] STROBE_N = fbh_pkg::CNT_W'(fbh_pkg::STROBE_CYC - 1);
    localparam logic [fbh_pkg::CNT_W-1:0] RESET_N  = fbh_pkg::CNT_W'(fbh_pkg::RESET_CYC - 1);

    // ****************************************************************
    // pin images
    // ****************************************************************
    function automatic fbh_pkg::fbh_pins_t idle_pins(input logic bm);
        fbh_pkg::fbh_pins_t p;
        p = '0;
        // standby: deselected, outputs disabled, reset released
        p.chip_select_n   = 1'b1; // RULE_18
        p.output_enable_n = 1'b1; // RULE_16
        p.write_strobe_n  = 1'b1;
        p.hw_reset_n      = 1'b1;
        p.width_select_n  = ~bm;
        return p;
    endfunction

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cur_next   = cur_reg;
        pins_next  = pins_reg;
        ready_next = ready_reg;
        rv_next    = 1'b0;
        rd_next    = rd_reg;
        unique case (state_reg)
            FBH_IDLE: begin
                // while busy req_ready is low, so a request is simply left waiting
                if (req_valid && ready_reg) begin
                    cur_next   = req;
                    ready_next = 1'b0;
                    cnt_next   = SETUP_N;
                    state_next = FBH_SETUP;
                    pins_next  = idle_pins(req.byte_mode);
                    pins_next.width_select_n = ~req.byte_mode; // RULE_03 RULE_10
                    pins_next.addr = req.addr; // RULE_06
                    if (req.byte_mode) begin
                        // top pin becomes the lowest address bit
                        pins_next.dq_out[DATA_W-1] = req.low_addr; // RULE_05
                        pins_next.dq_oe[DATA_W-1]  = 1'b1;
                    end
                    unique case (req.op)
                        fbh_pkg::FBH_OP_RESET: begin
                            // low through setup and strobe, well past the minimum pulse
                            pins_next.hw_reset_n = 1'b0; // RULE_17
                            cnt_next = RESET_N;
                        end
                        fbh_pkg::FBH_OP_PROTECT, fbh_pkg::FBH_OP_UNPROTECT: begin
                            // only a flag: the board lifts the reset pin to the high level
                            pins_next.elevated_control_level = 1'b1; // RULE_14
                            pins_next.addr[fbh_pkg::PROT_A1] = 1'b1; // RULE_14
                            pins_next.addr[fbh_pkg::PROT_A0] = 1'b0; // RULE_14
                            pins_next.addr[fbh_pkg::PROT_A6] =
                                (req.op == fbh_pkg::FBH_OP_UNPROTECT); // RULE_15
                        end
                        default: ;
                    endcase
                end
            end
            FBH_SETUP: begin
                // address, width and low address bit settle before any strobe falls
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - 1'b1;
                end else begin
                    cnt_next   = STROBE_N;
                    state_next = FBH_STROBE;
                    pins_next.chip_select_n = 1'b0;
                    if (cur_reg.op == fbh_pkg::FBH_OP_READ) begin
                        pins_next.output_enable_n = 1'b0; // RULE_01
                    end else if (cur_reg.op != fbh_pkg::FBH_OP_RESET) begin
                        // write, program, erase, protect cycles
                        // one bus write per request: a fast-program pair is simply two
                        // consecutive write requests, with no extra sequencing here
                        pins_next.write_strobe_n = 1'b0; // RULE_02 RULE_11
                        pins_next.dq_out[7:0] = cur_reg.wdata[7:0];
                        pins_next.dq_oe[7:0]  = 8'hff;
                        if (!cur_reg.byte_mode) begin
                            pins_next.dq_out[DATA_W-1:8] = cur_reg.wdata[DATA_W-1:8];
                            pins_next.dq_oe[DATA_W-1:8]  = '1; // RULE_03
                        end
                    end else begin
                        // a reset request keeps the bus deselected for its whole pulse
                        pins_next.chip_select_n = 1'b1;
                    end
                end
            end
            FBH_STROBE: begin
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - 1'b1;
                end else begin
                    state_next = FBH_HOLD;
                    if (cur_reg.op == fbh_pkg::FBH_OP_READ) begin
                        // taken on the last strobe cycle, while the flash still drives
                        // byte reads take only the low lane; lines eight..fourteen float
                        if (cur_reg.byte_mode) begin
                            rd_next = {{(DATA_W-8){1'b0}}, dq_in[7:0]}; // RULE_04
                        end else begin
                            rd_next = dq_in; // RULE_03 RULE_13
                        end
                    end
                    // all strobes rise together; the flash ends the cycle on the first
                    pins_next.chip_select_n   = 1'b1;
                    pins_next.output_enable_n = 1'b1;
                    pins_next.write_strobe_n  = 1'b1;
                    pins_next.hw_reset_n      = 1'b1;
                end
            end
            FBH_HOLD: begin
                // data and elevated level held one cycle past the strobe edge
                pins_next  = idle_pins(cur_reg.byte_mode);
                // address stays too, so it never moves while flash outputs turn off
                pins_next.addr = pins_reg.addr;
                rv_next    = 1'b1;
                ready_next = 1'b1;
                state_next = FBH_IDLE;
            end
            default: begin
                state_next = FBH_IDLE;
                ready_next = 1'b1;
                pins_next  = idle_pins(1'b0);
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // synchronous reset: standby pins, ready high, no response pending
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= FBH_IDLE;
            cnt_reg   <= '0;
            cur_reg   <= '0;
            pins_reg  <= idle_pins(1'b0);
            ready_reg <= 1'b1;
            rv_reg    <= 1'b0;
            rd_reg    <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            cur_reg   <= cur_next;
            pins_reg  <= pins_next;
            ready_reg <= ready_next;
            rv_reg    <= rv_next;
            rd_reg    <= rd_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // every output is a flop, so no decode glitch ever reaches a flash pin
    assign req_ready = ready_reg;
    assign rsp_valid = rv_reg;
    assign rsp_data  = rd_reg;
    assign pins      = pins_reg;
endmodule // fbh_host
`default_nettype wire

// [fbh_host_sva.sv]
// port checker for the flash bus host controller
`default_nettype none
module fbh_host_sva (
    input wire logic               sys_clk,
    input wire logic               sys_rst,
    input wire fbh_pkg::fbh_req_t  req,
    input wire logic               req_valid,
    input wire logic               req_ready,
    input wire logic               rsp_valid,
    input wire fbh_pkg::fbh_pins_t pins
);
    // ****************************************************************
    // pin relations
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic rd;
    logic wr;
    assign rd = !pins.chip_select_n && !pins.output_enable_n;
    assign wr = !pins.write_strobe_n;
    AST_RD_LEVELS: assert property (rd |-> pins.write_strobe_n && pins.hw_reset_n)
        else $error("read strobe with write low");
    AST_WR_LEVELS: assert property (wr |-> !pins.chip_select_n && pins.output_enable_n)
        else $error("write strobe levels wrong");
    AST_WORD_WR: assert property (wr && pins.width_select_n |-> pins.dq_oe == 16'hffff)
        else $error("word write not on all lines");
    AST_BYTE_WR: assert property (wr && !pins.width_select_n |-> pins.dq_oe == 16'h80ff)
        else $error("byte write lines wrong");
    AST_RD_FLOAT: assert property (rd |-> pins.dq_oe == {!pins.width_select_n, 15'h0})
        else $error("host drives data during read");
    AST_PROT_ADDR: assert property (wr && pins.elevated_control_level |-> pins.addr[1:0] == 2'h2)
        else $error("protect address bits wrong");
    AST_RST_HOLD: assert property ($fell(pins.hw_reset_n) |->
        (!pins.hw_reset_n && pins.chip_select_n)[*8] ##4 !pins.hw_reset_n)
        else $error("reset pulse too short");
    AST_OP_TIME: assert property (req_valid && req_ready && req.op != fbh_pkg::FBH_OP_RESET
        |=> !req_ready[*5] ##1 rsp_valid && req_ready)
        else $error("operation answer late");
    AST_IDLE_PINS: assert property (req_ready |-> pins.chip_select_n && pins.output_enable_n
        && pins.write_strobe_n && pins.dq_oe == 16'h0000)
        else $error("bus not in standby while idle");
    AST_COV_PROT: cover property (wr && pins.elevated_control_level && !pins.addr[6]);
    AST_COV_UNPROT: cover property (wr && pins.elevated_control_level && pins.addr[6]);
    AST_COV_BYTE_RD: cover property (rd && !pins.width_select_n);
    AST_COV_RESET: cover property ($fell(pins.hw_reset_n));
endmodule // fbh_host_sva
bind fbh_host fbh_host_sva i_fbh_host_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins));
`default_nettype wire

// [fbh_flash_model.sv]
// behavioural flash device on the far side of the host pins
`default_nettype none
module fbh_flash_model #(
    parameter logic [7:0] ID_CODE = 8'h3c // arbitrary value
) (
    input wire logic               sys_clk,
    input wire fbh_pkg::fbh_pins_t pins,
    output logic [15:0]            dq_in
);
    // ****************************************************************
    // array, command latches and data lines
    // ****************************************************************
    logic [7:0]  mem [32];
    logic [4:0]  ba, wa;
    logic        id_mode, prot, wp, w6, tgl, rd_on, on, wr_on, wl, fast, arm;
    logic [15:0] drv;
    initial begin
        for (int i = 0; i < 32; i++) mem[i] = 8'(i * 7 + 3);
        {id_mode, prot, tgl, wl, fast, arm} = 6'h0;
    end
    // released lines flip every cycle so a stale value never passes
    always @(posedge sys_clk) tgl <= ~tgl;
    assign ba = {pins.addr[3:0], pins.width_select_n ? 1'b0 : pins.dq_out[15]};
    assign rd_on = !pins.chip_select_n && !pins.output_enable_n && pins.write_strobe_n
        && pins.hw_reset_n;
    // a write cycle is select and strobe both low; select and strobe may rise
    // together, so the cycle ends on whichever rises first
    assign wr_on = !pins.chip_select_n && !pins.write_strobe_n && pins.hw_reset_n;
    // address latches as the cycle opens, data as it closes
    always @(posedge wr_on) {wl, wa, wp, w6} = {1'b1, ba, pins.elevated_control_level,
        pins.addr[6]};
    always @(negedge wr_on) begin
        if (wl && pins.hw_reset_n === 1'b1) begin
            if (wp) prot = !w6;
            else if (pins.dq_out[7:0] == 8'h90) id_mode = 1'b1;
            else if (pins.dq_out[7:0] == 8'hf0) {id_mode, fast, arm} = 3'h0;
            else if (pins.dq_out[7:0] == 8'hc0) fast = 1'b1;
            else if (fast && !arm && pins.dq_out[7:0] == 8'ha0) arm = 1'b1;
            else if (prot || (fast && !arm)) arm = 1'b0;
            else if (pins.dq_out[7:0] == 8'h80) begin
                // sector erase: the upper address bits pick the sector
                for (int i = 0; i < 32; i++) if (i[4:3] == wa[4:3]) mem[i] = 8'hff;
            end else begin
                mem[wa] = pins.dq_out[7:0];
                if (pins.width_select_n) mem[wa + 5'h1] = pins.dq_out[15:8];
                arm = 1'b0;
            end
        end
        wl = 1'b0;
    end
    always @(negedge pins.hw_reset_n) {id_mode, fast, arm} = 3'h0;
    always_comb begin
        drv = pins.width_select_n ? {mem[ba + 5'h1], mem[ba]} : {8'h00, mem[ba]};
        if (id_mode) drv = {8'h00, ID_CODE};
        for (int i = 0; i < 16; i++) begin
            on = rd_on && (pins.width_select_n || i < 8);
            dq_in[i] = pins.dq_oe[i] ? pins.dq_out[i] : on ? drv[i] : tgl ^ i[0];
        end
    end
endmodule // fbh_flash_model
`default_nettype wire

// [fbh_host_tb_top.sv]
// self-checking bench for the flash bus host controller
`default_nettype none
module fbh_host_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // bench
    // ****************************************************************
    localparam logic [7:0] ID = 8'h5a; // arbitrary value
    logic               sys_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               req_valid = 1'b0;
    fbh_pkg::fbh_req_t  req = '0;
    logic               req_ready, rsp_valid;
    logic [15:0]        rsp_data, dq_in, last_exp = 16'h0000;
    fbh_pkg::fbh_pins_t pins;
    logic [15:0]        expq [$];
    logic [7:0]         img [32];
    int                 miscompares = 0;
    int                 tests_run = 0;
    integer             seed = 84;
    always #25 sys_clk = ~sys_clk;
    fbh_host i_fbh_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
        .dq_in(dq_in));
    fbh_flash_model #(.ID_CODE(ID)) i_fbh_flash_model (.sys_clk(sys_clk), .pins(pins),
        .dq_in(dq_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // rsp_data holds the last read, so other operations expect it again
    task automatic op(input logic [2:0] o, input logic bm, la, input logic [18:0] a,
                      input logic [15:0] d, rd);
        int n;
        if (o == 3'h0) last_exp = rd;
        expq.push_back(last_exp);
        req = '{fbh_pkg::fbh_op_t'(o), bm, la, a, d};
        req_valid = 1'b1;
        @(posedge sys_clk);
        #5 req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #5 n++;
        end
        if (n == 40) begin
            miscompares++;
            stop_test();
        end
    endtask
    // looked at mid-cycle, well clear of the edge that launches the response
    always @(negedge sys_clk) begin
        if (rsp_valid === 1'b1) check(rsp_data, expq.pop_front());
    end
    initial begin
        #200000 miscompares++;
        stop_test();
    end
    initial begin
        logic [18:0] a;
        logic [15:0] d;
        logic        l;
        for (int i = 0; i < 32; i++) img[i] = 8'(i * 7 + 3);
        repeat (20) @(posedge sys_clk);
        #5 sys_rst = 1'b0;
        op(3'h0, 1'b0, 1'b0, 19'h00002, 16'h0000, {img[5], img[4]});
        $display("test power-up read done");
        for (int i = 0; i < 8; i++) begin
            a = 19'($random(seed));
            d = 16'($random(seed)) & 16'hff7f;
            l = i[0] & a[5];
            op(3'h1, i[0], l, a, d, 16'h0000);
            img[{a[3:0], l}] = d[7:0];
            if (!i[0]) img[{a[3:0], 1'b1}] = d[15:8];
            op(3'h0, i[0], l, a, 16'h0000, i[0] ? {8'h00, img[{a[3:0], l}]}
                : {img[{a[3:0], 1'b1}], img[{a[3:0], 1'b0}]});
        end
        $display("test word and byte transfers done");
        op(3'h1, 1'b0, 1'b0, 19'h00555, 16'h0090, 16'h0000);
        op(3'h0, 1'b0, 1'b0, 19'h00000, 16'h0000, {8'h00, ID});
        op(3'h2, 1'b0, 1'b0, 19'h00000, 16'h0000, 16'h0000);
        op(3'h0, 1'b0, 1'b0, 19'h00000, 16'h0000, {img[1], img[0]});
        $display("test id mode and reset done");
        op(3'h3, 1'b0, 1'b0, 19'h00008, 16'h0000, 16'h0000);
        op(3'h1, 1'b0, 1'b0, 19'h00003, 16'h1234, 16'h0000);
        op(3'h0, 1'b0, 1'b0, 19'h00003, 16'h0000, {img[7], img[6]});
        op(3'h4, 1'b0, 1'b0, 19'h00008, 16'h0000, 16'h0000);
        op(3'h1, 1'b0, 1'b0, 19'h00003, 16'h1234, 16'h0000);
        op(3'h0, 1'b0, 1'b0, 19'h00003, 16'h0000, 16'h1234);
        $display("test sector protection done");
        op(3'h1, 1'b0, 1'b0, 19'h00000, 16'h00c0, 16'h0000);
        op(3'h1, 1'b0, 1'b0, 19'h00002, 16'h4321, 16'h0000);
        op(3'h0, 1'b0, 1'b0, 19'h00002, 16'h0000, {img[5], img[4]});
        op(3'h1, 1'b0, 1'b0, 19'h00000, 16'h00a0, 16'h0000);
        op(3'h1, 1'b0, 1'b0, 19'h00002, 16'h5678, 16'h0000);
        op(3'h0, 1'b0, 1'b0, 19'h00002, 16'h0000, 16'h5678);
        op(3'h1, 1'b0, 1'b0, 19'h00000, 16'h00f0, 16'h0000);
        $display("test fast program done");
        op(3'h1, 1'b0, 1'b0, 19'h00004, 16'h0080, 16'h0000);
        op(3'h0, 1'b0, 1'b0, 19'h00005, 16'h0000, 16'hffff);
        op(3'h0, 1'b0, 1'b0, 19'h00003, 16'h0000, 16'h1234);
        @(posedge sys_clk);
        #5 $display("test sector erase done");
        stop_test();
    end
endmodule // fbh_host_tb_top
`default_nettype wire
